/* verilog/cfg_clk_consts.svh */
// constants of the configuration clock source selector
`ifndef CFG_CLK_CONSTS_SVH
`define CFG_CLK_CONSTS_SVH
`define CLK_MHZ 40
`define INT_OSC_MIN_MHZ 170
`define INT_OSC_MAX_MHZ 230
`define CFG_CLK_MHZ 250
`define REF_25_MHZ 25
`define REF_100_MHZ 100
`define REF_125_MHZ 125
`define FREQ_SEL_25 2'h0
`define FREQ_SEL_100 2'h1
`define FREQ_SEL_125 2'h2
`define MULT_W 8
`define FIRST_SECTION_KB 200
`define FIRST_SECTION_BYTES (`FIRST_SECTION_KB * 1024)
`define BYTE_CNT_W 18
`define LOCK_TIMEOUT_US 100
`define LOCK_TIMEOUT_CYC (`LOCK_TIMEOUT_US * `CLK_MHZ)
`define TIMEOUT_W 13
`define GATE_GAP_CYC 4'h4
`define GAP_W 4
`define MON_WINDOW_CYC 6'h3f
`define MON_WIN_W 6
`define MON_MIN_EDGES 6'h08
`define MON_STABLE_WINDOWS 3'h4
`define MON_STB_W 3
`endif

/* verilog/cfg_clk_pkg.sv */
// types of the configuration clock source selector
`default_nettype none
package cfg_clk_pkg;
    typedef enum logic [2:0] {SIdle, SIntLoad, SWaitLock, SGateGap, SExtLoad, SFail} cfgState_type;
endpackage
`default_nettype wire

/* verilog/ref_mon_if.sv */
// link between selector and external reference monitor
`default_nettype none
interface ref_mon_if;
    logic enable;
    logic locked;
    modport ctrl (output enable, input locked);
    modport mon (input enable, output locked);
endinterface
`default_nettype wire

/* verilog/ref_clk_monitor.sv */
// activity and stability monitor for the external reference
`include "cfg_clk_consts.svh"
`default_nettype none
module ref_clk_monitor
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic extRefClockIn,
    ref_mon_if.mon mon
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic [`MON_WIN_W-1:0] winCnt_r;
    logic [`MON_WIN_W-1:0] edgeCnt_r;
    logic [`MON_STB_W-1:0] goodCnt_r;
    logic locked_r;
    wire edgeSeen = sync2_r != prev_r;
    wire winEnd = winCnt_r == `MON_WINDOW_CYC;
    wire winGood = edgeCnt_r >= `MON_MIN_EDGES;
    wire stableNow = goodCnt_r == `MON_STABLE_WINDOWS;
    // ********************************************
    // pin synchroniser and window counting
    // ********************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= extRefClockIn;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end
    // lock drops on any quiet window: a stopped reference must never look stable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            winCnt_r <= '0;
            edgeCnt_r <= '0;
            goodCnt_r <= '0;
            locked_r <= 1'b0;
        end
        else if (!mon.enable)
        begin
            winCnt_r <= '0;
            edgeCnt_r <= '0;
            goodCnt_r <= '0;
            locked_r <= 1'b0;
        end
        else if (winEnd)
        begin
            winCnt_r <= '0;
            edgeCnt_r <= '0;
            goodCnt_r <= !winGood ? '0 : stableNow ? goodCnt_r : goodCnt_r + 1'b1;
            locked_r <= winGood && stableNow;
        end
        else
        begin
            winCnt_r <= winCnt_r + 1'b1;
            edgeCnt_r <= (edgeSeen && edgeCnt_r != '1) ? edgeCnt_r + 1'b1 : edgeCnt_r;
        end
    end
    assign mon.locked = locked_r;
endmodule
`default_nettype wire

/* verilog/config_clock_source_select.sv */
// configuration clock source selection and handover controller
// Functional notes
// - internal oscillator unless external reference selected
// - external source loads bulk at 250 MHz
// - internal oscillator runs 170-230 MHz, imprecise
// - first ~200 KB on internal oscillator, except in warm reconfiguration
// - multiply reference by matching factor to 250
// - warm reconfiguration uses external reference only
// - missing or wrong reference may fail configuration
`include "cfg_clk_consts.svh"
`default_nettype none
module config_clock_source_select
    import cfg_clk_pkg::*;
#(
    parameter logic [`BYTE_CNT_W-1:0] SECTION_BYTES = `BYTE_CNT_W'(`FIRST_SECTION_BYTES),
    parameter logic [`TIMEOUT_W-1:0] LOCK_TIMEOUT = `TIMEOUT_W'(`LOCK_TIMEOUT_CYC)
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic extRefSelect,
    input wire logic [1:0] extRefFreqSel,
    input wire logic ext_ref_clock_in,
    input wire logic configStart,
    input wire logic configByteValid,
    input wire logic configDone,
    output logic intOscEnable,
    output logic intClkGate,
    output logic extClkGate,
    output logic pllEnable,
    output logic [`MULT_W-1:0] pllMultX2,
    output logic [7:0] cfgClkNominalMhz,
    output logic configFail
);
    cfgState_type state_r, state_nxt;
    logic [`BYTE_CNT_W-1:0] byteCnt_r;
    logic [`TIMEOUT_W-1:0] waitCnt_r;
    logic [`GAP_W-1:0] gapCnt_r;
    logic warmBoot_r;
    logic intOscEnable_r, intClkGate_r, extClkGate_r, pllEnable_r, configFail_r;
    logic [`MULT_W-1:0] pllMultX2_r;
    logic [7:0] cfgClkMhz_r;
    ref_mon_if refMon();
    // ********************************************
    // reference monitor
    // ********************************************
    ref_clk_monitor monitor (
        .clk(clk),
        .rst_n(rst_n),
        .extRefClockIn(ext_ref_clock_in),
        .mon(refMon)
    );
    // monitor only runs while the pll is wanted, so a floating pin is ignored
    assign refMon.enable = pllEnable_r;
    // ********************************************
    // decoding
    // ********************************************
    // factor kept in half units because 100 MHz needs 2.5
    wire freqOk = extRefFreqSel == `FREQ_SEL_25 || extRefFreqSel == `FREQ_SEL_100
        || extRefFreqSel == `FREQ_SEL_125;
    wire [`MULT_W-1:0] multX2 =
        extRefFreqSel == `FREQ_SEL_25 ? `MULT_W'(2 * `CFG_CLK_MHZ / `REF_25_MHZ) :
        extRefFreqSel == `FREQ_SEL_100 ? `MULT_W'(2 * `CFG_CLK_MHZ / `REF_100_MHZ) :
        extRefFreqSel == `FREQ_SEL_125 ? `MULT_W'(2 * `CFG_CLK_MHZ / `REF_125_MHZ) : '0;
    wire sectionDone = byteCnt_r >= SECTION_BYTES;
    wire lockTimeout = waitCnt_r >= LOCK_TIMEOUT;
    wire gapDone = gapCnt_r == `GATE_GAP_CYC;
    wire useExtNow = state_nxt == SExtLoad;
    wire useIntNow = state_nxt == SIntLoad;
    wire pllWanted = state_nxt == SWaitLock || state_nxt == SGateGap || state_nxt == SExtLoad;
    // internal oscillator only reports its midpoint; its true rate is not trimmed
    wire [7:0] nominalMhz = useExtNow ? 8'(`CFG_CLK_MHZ) :
        useIntNow ? 8'((`INT_OSC_MIN_MHZ + `INT_OSC_MAX_MHZ) / 2) : 8'h00;
    // ********************************************
    // sequencing
    // ********************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SIdle:
                if (configStart)
                begin
                    if (!extRefSelect)
                        state_nxt = SIntLoad;
                    else if (warmBoot_r)
                        state_nxt = SWaitLock;
                    else
                        state_nxt = SIntLoad;
                end
            SIntLoad:
                if (configDone)
                    state_nxt = SIdle;
                else if (extRefSelect && sectionDone)
                    state_nxt = SWaitLock;
            SWaitLock:
                if (!freqOk || lockTimeout)
                    state_nxt = SFail;
                else if (refMon.locked)
                    state_nxt = SGateGap;
            SGateGap:
                if (!refMon.locked)
                    state_nxt = SFail;
                else if (gapDone)
                    state_nxt = SExtLoad;
            SExtLoad:
                if (configDone)
                    state_nxt = SIdle;
                else if (!refMon.locked)
                    state_nxt = SFail;
            SFail:
                state_nxt = SFail;  // no recovery short of reset
            default:
                state_nxt = SIdle;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= SIdle;
            byteCnt_r <= '0;
            waitCnt_r <= '0;
            gapCnt_r <= '0;
            warmBoot_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            byteCnt_r <= state_r == SIdle ? '0 :
                (configByteValid && !sectionDone) ? byteCnt_r + 1'b1 : byteCnt_r;
            waitCnt_r <= state_r == SWaitLock ? waitCnt_r + 1'b1 : '0;
            gapCnt_r <= state_r == SGateGap ? gapCnt_r + 1'b1 : '0;
            // only an external-reference boot makes later reconfiguration external-only
            if (configDone && extRefSelect && state_r == SExtLoad)
                warmBoot_r <= 1'b1;
        end
    end
    // ********************************************
    // registered outputs
    // ********************************************
    // gates come from the next state, so the external gate can never rise before the gap has passed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            intOscEnable_r <= 1'b1;
            intClkGate_r <= 1'b0;
            extClkGate_r <= 1'b0;
            pllEnable_r <= 1'b0;
            pllMultX2_r <= '0;
            cfgClkMhz_r <= 8'h00;
            configFail_r <= 1'b0;
        end
        else
        begin
            intOscEnable_r <= !(warmBoot_r && extRefSelect);
            intClkGate_r <= useIntNow;
            extClkGate_r <= useExtNow;
            pllEnable_r <= pllWanted;
            pllMultX2_r <= pllWanted ? multX2 : '0;
            cfgClkMhz_r <= nominalMhz;
            configFail_r <= state_nxt == SFail;
        end
    end
    assign intOscEnable = intOscEnable_r;
    assign intClkGate = intClkGate_r;
    assign extClkGate = extClkGate_r;
    assign pllEnable = pllEnable_r;
    assign pllMultX2 = pllMultX2_r;
    assign cfgClkNominalMhz = cfgClkMhz_r;
    assign configFail = configFail_r;
endmodule
`default_nettype wire

/* dv/cfg_clk_chk.sv */
// port checker of the configuration clock selector
`include "cfg_clk_consts.svh"
`default_nettype none
module cfg_clk_chk
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic extRefSelect,
    input wire logic [1:0] extRefFreqSel,
    input wire logic configStart,
    input wire logic configDone,
    input wire logic intOscEnable,
    input wire logic intClkGate,
    input wire logic extClkGate,
    input wire logic pllEnable,
    input wire logic [`MULT_W-1:0] pllMultX2,
    input wire logic [7:0] cfgClkNominalMhz,
    input wire logic configFail
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic idle;
    assign idle = !intClkGate && !pllEnable && !configFail;
    // lock takes hundreds of cycles, so the handover stays dark at least this long
    sequence s_dark; !extClkGate [*4]; endsequence
    property p_excl; !(intClkGate && extClkGate); endproperty
    a_excl: assert property (p_excl) else $error("both clock gates high");
    property p_gap; $fell(intClkGate) && pllEnable |-> s_dark; endproperty
    a_gap: assert property (p_gap) else $error("handover without dark gap");
    property p_int; intClkGate |-> cfgClkNominalMhz == 8'hc8; endproperty
    a_int: assert property (p_int) else $error("internal rate wrong");
    property p_ext; extClkGate |-> pllEnable && cfgClkNominalMhz == 8'hfa; endproperty
    a_ext: assert property (p_ext) else $error("external rate wrong");
    property p_mult; pllEnable && extRefFreqSel != 2'h3 |->
        pllMultX2 == (extRefFreqSel == 2'h0 ? 8'h14 : extRefFreqSel == 2'h1 ? 8'h05 : 8'h04); endproperty
    a_mult: assert property (p_mult) else $error("multiplier factor wrong");
    property p_start; configStart && idle && !extRefSelect |=> intClkGate && !pllEnable; endproperty
    a_start: assert property (p_start) else $error("start not on internal clock");
    property p_local; !extRefSelect |-> !pllEnable && !extClkGate && intOscEnable; endproperty
    a_local: assert property (p_local) else $error("reference used while not chosen");
    property p_stick; configFail |=> configFail && !intClkGate && !extClkGate; endproperty
    a_stick: assert property (p_stick) else $error("fail not sticky");
    property p_done; configDone && (intClkGate || extClkGate) |=> !intClkGate && !extClkGate; endproperty
    a_done: assert property (p_done) else $error("gate stands after done");
endmodule
bind config_clock_source_select cfg_clk_chk chk (.*);
`default_nettype wire

/* dv/ref_osc_model.sv */
// board reference oscillator model
`default_nettype none
module ref_osc_model
(
    input wire logic run,
    input wire logic [1:0] freqSel,
    output logic refClk
);
    timeunit 1ns;
    timeprecision 100ps;
    // run low models an unfitted oscillator: the pin shows no edges
    initial refClk = 1'b0;
    always
    begin
        #(freqSel == 2'h0 ? 20.0 : freqSel == 2'h1 ? 5.0 : 4.0);
        refClk = run ? !refClk : 1'b0;
    end
endmodule
`default_nettype wire

/* dv/config_clock_source_select_tb.sv */
// self-checking bench of the configuration clock selector
`include "cfg_clk_consts.svh"
`default_nettype none
module config_clock_source_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, extRefSelect, configStart, configByteValid, configDone, refRun, extRef;
    logic [1:0] extRefFreqSel;
    logic intOscEnable, intClkGate, extClkGate, pllEnable, configFail;
    logic [`MULT_W-1:0] pllMultX2;
    logic [7:0] cfgClkNominalMhz;
    int errors = 0;
    int cmp_count = 0;
    config_clock_source_select #(.SECTION_BYTES(18'h10), .LOCK_TIMEOUT(13'h3e8)) dut (.clk(clk), .rst_n(rst_n),
        .extRefSelect(extRefSelect), .extRefFreqSel(extRefFreqSel), .ext_ref_clock_in(extRef),
        .configStart(configStart), .configByteValid(configByteValid), .configDone(configDone),
        .intOscEnable(intOscEnable), .intClkGate(intClkGate), .extClkGate(extClkGate), .pllEnable(pllEnable),
        .pllMultX2(pllMultX2), .cfgClkNominalMhz(cfgClkNominalMhz), .configFail(configFail));
    ref_osc_model osc (.run(refRun), .freqSel(extRefFreqSel), .refClk(extRef));
    task automatic close_out;
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rst(input logic s, input logic [1:0] f);
        rst_n <= 1'b0;
        extRefSelect <= s;
        extRefFreqSel <= f;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
    endtask
    // d high gives a done pulse, low a start pulse
    task automatic pulse(input bit d);
        if (d)
            configDone <= 1'b1;
        else
            configStart <= 1'b1;
        @(posedge clk);
        configDone <= 1'b0;
        configStart <= 1'b0;
        #1;
    endtask
    task automatic feed(input int n);
        configByteValid <= 1'b1;
        repeat (n) @(posedge clk);
        configByteValid <= 1'b0;
        #1;
    endtask
    // w high waits for the fail flag, low for the external gate
    task automatic wait_for(input bit w);
        int i;
        // look a step after each edge, never in the step that launches the flag
        for (i = 0; i < 1200 && (w ? configFail : extClkGate) !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk(w ? "configFail" : "extClkGate", 8'h01, {7'h0, w ? configFail : extClkGate});
        if (i == 1200)
            close_out;
    endtask
    task automatic t_internal;
        rst(1'b0, 2'h0);
        pulse(1'b0);
        chk("intGate", 8'h01, {7'h0, intClkGate});
        chk("nominal", 8'hc8, cfgClkNominalMhz);
        feed(20);
        chk("pllOff", 8'h00, {7'h0, pllEnable});
        pulse(1'b1);
        chk("intGate", 8'h00, {7'h0, intClkGate});
        chk("idleRate", 8'h00, cfgClkNominalMhz);
    endtask
    task automatic t_cold(input logic [1:0] f);
        rst(1'b1, f);
        refRun <= 1'b1;
        pulse(1'b0);
        chk("intGate", 8'h01, {7'h0, intClkGate});
        feed(15);
        chk("pllEarly", 8'h00, {7'h0, pllEnable});
        feed(1);
        @(posedge clk);
        #1;
        chk("pllOn", 8'h01, {7'h0, pllEnable});
        chk("mult", f == 2'h0 ? 8'h14 : f == 2'h1 ? 8'h05 : 8'h04, pllMultX2);
        wait_for(1'b0);
        chk("nominal", 8'hfa, cfgClkNominalMhz);
        chk("noFail", 8'h00, {7'h0, configFail});
        pulse(1'b1);
        chk("extGate", 8'h00, {7'h0, extClkGate});
        // the oscillator enable follows the warm-boot flag one register later
        @(posedge clk);
        #1;
        chk("oscOff", 8'h00, {7'h0, intOscEnable});
    endtask
    task automatic t_warm;
        pulse(1'b0);
        chk("intGate", 8'h00, {7'h0, intClkGate});
        chk("pllOn", 8'h01, {7'h0, pllEnable});
        wait_for(1'b0);
        pulse(1'b1);
    endtask
    task automatic t_fail(input bit bad);
        rst(1'b1, bad ? 2'h3 : 2'h0);
        refRun <= bad;
        pulse(1'b0);
        feed(16);
        wait_for(1'b1);
        chk("gates", 8'h00, {6'h0, intClkGate, extClkGate});
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        {rst_n, extRefSelect, configStart, configByteValid, configDone, refRun} = 6'h0;
        extRefFreqSel = 2'h0;
        t_internal;
        for (int f = 0; f < 3; f++)
            t_cold(2'(f));
        t_warm;
        t_fail(1'b0);
        t_fail(1'b1);
        close_out;
    end
endmodule
`default_nettype wire
